// ### irq_summary_pkg.sv
// Constants for the interrupt summary block: register offsets, field
// positions, reset values and debounce timing.
// Assumes an 8-bit register port with 8-bit addresses.
package irq_summary_pkg;
  localparam int unsigned ADDR_W            = 8;
  localparam int unsigned DATA_W            = 8;
  localparam int unsigned NUM_BUCK          = 3;
  localparam logic [7:0]  GROUP_SUMMARY_ADR = 8'h06;
  localparam logic [7:0]  LIMIT_STATUS_ADR  = 8'h08;
  localparam logic [7:0]  LIMIT_MASK_ADR    = 8'h09;
  localparam logic [7:0]  LIMIT_LIVE_ADR    = 8'h0a;
  // Category bit positions
  localparam int unsigned CHARGER_BIT       = 0;
  localparam int unsigned BUCK_ONE_BIT      = 1;
  localparam int unsigned BUCK_TWO_BIT      = 2;
  localparam int unsigned BUCK_THREE_BIT    = 3;
  localparam int unsigned LINEAR_BIT        = 4;
  localparam int unsigned BUTTON_BIT        = 5;
  localparam int unsigned TEMP_BIT          = 6;
  localparam int unsigned MISC_BIT          = 7;
  localparam logic [2:0]  MASK_RESET        = 3'h7;
  localparam logic [2:0]  STATUS_RESET      = 3'h0;
  localparam logic [4:0]  UNUSED_ZERO       = 5'h00;
  // Debounce time of the current-limit fault
  localparam int unsigned DEBOUNCE_NS       = 1000;
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned DEBOUNCE_CYCLES   = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES       = 3;
endpackage : irq_summary_pkg

// ### fault_debounce.sv
// Synchroniser and debouncer for one asynchronous current-limit fault pin.
// Assumes the fault is a level from analog logic outside the clock domain.
`timescale 1ns/1ps
module fault_debounce
  import irq_summary_pkg::*;
#(
  parameter int unsigned CYCLES = DEBOUNCE_CYCLES
)
(
  input  wire logic i_core_clk, // System clock
  input  wire logic i_reset,    // Async reset, active high
  input  wire logic i_fault,    // Raw fault level
  output logic      o_live      // Debounced fault level
);
  logic [SYNC_STAGES-1:0] sync_reg;
  logic [15:0]            count_reg;
  logic [15:0]            count_next;
  logic                   live_reg;
  wire                    agreed = sync_reg[1] == sync_reg[2];
  wire                    differs = agreed && (sync_reg[2] != live_reg);

  // Count only while the settled input differs from the held level
  assign count_next = differs ? count_reg + 16'h0001 : 16'h0000;

  // Three-stage sync; stage 0 feeds stage 1 only
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sync_reg  <= '0;
      count_reg <= 16'h0000;
      live_reg  <= 1'b0;
    end
    else
    begin
      sync_reg  <= {sync_reg[1:0], i_fault};
      count_reg <= count_next;
      // Level must persist longer than the debounce time
      if (differs && count_reg >= CYCLES[15:0])
        live_reg <= sync_reg[2];
    end
  end

  assign o_live = live_reg;
endmodule : fault_debounce

// ### irq_summary.sv
// Interrupt summary logic: group category register, buck low-side
// current-limit status, mask and live registers, and the interrupt pin.
// Assumes a simple synchronous register port driven by the serial
// front end; the other groups deliver their OR-ed status as inputs.
`timescale 1ns/1ps
module irq_summary
  import irq_summary_pkg::*;
#(
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYCLES
)
(
  input  wire logic                                   i_core_clk,      // System clock
  input  wire logic                                   i_reset,         // Async reset, high
  input  wire logic [irq_summary_pkg::ADDR_W-1:0]     i_addr,          // Register address
  input  wire logic                                   i_wr_en,         // Write strobe
  input  wire logic [irq_summary_pkg::DATA_W-1:0]     i_wr_data,       // Write data
  input  wire logic                                   i_rd_en,         // Read strobe
  output logic      [irq_summary_pkg::DATA_W-1:0]     o_rd_data,       // Read data, registered
  input  wire logic [irq_summary_pkg::NUM_BUCK-1:0]   i_buck_fault,    // Raw low-side limit faults
  input  wire logic [irq_summary_pkg::NUM_BUCK-1:0]   i_buck_other,    // Other buck status ORs
  input  wire logic [irq_summary_pkg::NUM_BUCK-1:0]   i_buck_other_irq,// Other buck unmasked ORs
  input  wire logic                                   i_charger_any,   // Charger status OR
  input  wire logic                                   i_linear_any,    // Linear regulator OR
  input  wire logic                                   i_button_any,    // Push-button OR
  input  wire logic                                   i_temp_any,      // Temperature OR
  input  wire logic                                   i_misc_any,      // Other status OR
  input  wire logic                                   i_ext_irq,       // Other unmasked status OR
  output logic                                        o_irq_out_n      // Interrupt pin, low active
);
  logic [NUM_BUCK-1:0] status_reg;
  logic [NUM_BUCK-1:0] status_next;
  logic [NUM_BUCK-1:0] mask_reg;
  logic [NUM_BUCK-1:0] live;
  logic [NUM_BUCK-1:0] live_prev_reg;
  logic [DATA_W-1:0]   rd_data_reg;
  logic [DATA_W-1:0]   rd_data_next;
  logic                irq_n_reg;

  // Debounce each buck fault separately
  genvar g;
  generate
    for (g = 0; g < NUM_BUCK; g++)
    begin : g_deb
      fault_debounce #(.CYCLES(DEBOUNCE)) u_deb (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_fault    (i_buck_fault[g]),
        .o_live     (live[g])
      );
    end
  endgenerate

  // Address decode
  wire sel_summary = i_addr == GROUP_SUMMARY_ADR;
  wire sel_status  = i_addr == LIMIT_STATUS_ADR;
  wire sel_mask    = i_addr == LIMIT_MASK_ADR;
  wire sel_live    = i_addr == LIMIT_LIVE_ADR;

  // Rising edge of the debounced fault sets status
  wire [NUM_BUCK-1:0] set_evt = live & ~live_prev_reg;
  wire [NUM_BUCK-1:0] rd_clr  = (i_rd_en && sel_status) ? {NUM_BUCK{1'b1}} : '0;
  wire [NUM_BUCK-1:0] wr_clr  = (i_wr_en && sel_status) ? i_wr_data[NUM_BUCK-1:0] : '0;

  // Set wins over a clear in the same cycle so no event is lost
  assign status_next = (status_reg & ~(rd_clr | wr_clr)) | set_evt;

  // Category bits, pure ORs with no storage of their own
  wire [DATA_W-1:0] summary;
  assign summary[CHARGER_BIT]    = i_charger_any;
  assign summary[BUCK_ONE_BIT]   = status_reg[0] | i_buck_other[0];
  assign summary[BUCK_TWO_BIT]   = status_reg[1] | i_buck_other[1];
  assign summary[BUCK_THREE_BIT] = status_reg[2] | i_buck_other[2];
  assign summary[LINEAR_BIT]     = i_linear_any;
  assign summary[BUTTON_BIT]     = i_button_any;
  assign summary[TEMP_BIT]       = i_temp_any;
  assign summary[MISC_BIT]       = i_misc_any;

  // Read mux; unused bits return zero
  assign rd_data_next = sel_summary ? summary :
                        sel_status  ? {UNUSED_ZERO, status_reg} :
                        sel_mask    ? {UNUSED_ZERO, mask_reg} :
                        sel_live    ? {UNUSED_ZERO, live} :
                        8'h00;

  // Pin pulled low for any unmasked source in any group
  wire irq_any = |(status_reg & ~mask_reg) | |i_buck_other_irq | i_ext_irq;

  // Status and mask storage
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      status_reg    <= STATUS_RESET;
      mask_reg      <= MASK_RESET;
      live_prev_reg <= '0;
    end
    else
    begin
      status_reg    <= status_next;
      live_prev_reg <= live;
      // Only low bits stored; summary is read-only
      if (i_wr_en && sel_mask)
        mask_reg <= i_wr_data[NUM_BUCK-1:0];
    end
  end

  // Registered read data and pin
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      rd_data_reg <= 8'h00;
      irq_n_reg   <= 1'b1;
    end
    else
    begin
      if (i_rd_en)
        rd_data_reg <= rd_data_next;
      irq_n_reg <= ~irq_any;
    end
  end

  assign o_rd_data   = rd_data_reg;
  assign o_irq_out_n = irq_n_reg;

  // Checks: buck one category follows its status OR
  chk_summary_buck_or: assert property (@(posedge i_core_clk) disable iff (i_reset)
    summary[BUCK_ONE_BIT] == (status_reg[0] | i_buck_other[0]))
    else $error("buck one category mismatch");

  // Status holds with no clear in the cycle
  chk_status_sticky: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (status_reg[0] && !(i_rd_en && sel_status) && !(i_wr_en && sel_status && i_wr_data[0]))
    |=> status_reg[0])
    else $error("status dropped without clear");

  // A set needs a debounced fault behind it
  chk_status_set_live: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(status_reg[1]) |-> $past(live[1]))
    else $error("status set without debounced fault");

  // Read of the status register clears it
  chk_read_clears: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && sel_status && !set_evt[2]) |=> !status_reg[2])
    else $error("read did not clear status");

  // Unmasked status pulls the pin
  chk_pin_unmasked: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (status_reg[0] && !mask_reg[0]) |=> !o_irq_out_n)
    else $error("unmasked status left pin high");

  // Nothing unmasked anywhere releases the pin
  chk_pin_masked_idle: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ((status_reg & ~mask_reg) == '0 && !i_ext_irq && i_buck_other_irq == '0) |=> o_irq_out_n)
    else $error("pin low with nothing unmasked");

  // Upper bits of status and mask read zero
  chk_read_upper_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && (sel_status || sel_mask)) |=> o_rd_data[7:3] == UNUSED_ZERO)
    else $error("unused bits not zero");

  // Buck categories drop with their sources
  chk_summary_drops: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (status_reg == '0 && i_buck_other == '0) |-> summary[3:1] == 3'h0)
    else $error("category stuck after clear");

  // Charger category as seen on the read port
  chk_cat_charger_read: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && sel_summary) |=> o_rd_data[CHARGER_BIT] == $past(i_charger_any))
    else $error("charger category read wrong");

  // Buck two category on the read port
  chk_cat_buck_two: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && sel_summary) |=> o_rd_data[BUCK_TWO_BIT] == $past(status_reg[1] | i_buck_other[1]))
    else $error("buck two category read wrong");

  // Buck three category on the read port
  chk_cat_buck_three: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && sel_summary)
    |=> o_rd_data[BUCK_THREE_BIT] == $past(status_reg[2] | i_buck_other[2]))
    else $error("buck three category read wrong");

  // Linear regulator category on the read port
  chk_cat_linear_read: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && sel_summary) |=> o_rd_data[LINEAR_BIT] == $past(i_linear_any))
    else $error("linear category read wrong");

  // Push-button category on the read port
  chk_cat_button_read: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && sel_summary) |=> o_rd_data[BUTTON_BIT] == $past(i_button_any))
    else $error("button category read wrong");

  // Temperature category on the read port
  chk_cat_temp_read: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && sel_summary) |=> o_rd_data[TEMP_BIT] == $past(i_temp_any))
    else $error("temperature category read wrong");

  // Remaining sources category on the read port
  chk_cat_misc_read: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && sel_summary) |=> o_rd_data[MISC_BIT] == $past(i_misc_any))
    else $error("misc category read wrong");

  // No debounced fault, no new status
  chk_status_no_live: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!live[0] && !status_reg[0]) |=> !status_reg[0])
    else $error("status set without live fault");

  // Buck three status holds with no clear
  chk_status_sticky_three: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (status_reg[2] && !(i_rd_en && sel_status) && !(i_wr_en && sel_status && i_wr_data[2]))
    |=> status_reg[2])
    else $error("buck three status dropped");

  // A set in the same cycle as a clear wins
  chk_set_beats_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
    set_evt[1] |=> status_reg[1])
    else $error("set event lost");

  // Writing one clears buck one status
  chk_write_clears_one: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_wr_en && sel_status && i_wr_data[0] && !set_evt[0]) |=> !status_reg[0])
    else $error("write one did not clear");

  // Writing one clears buck three status
  chk_write_clears_three: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_wr_en && sel_status && i_wr_data[2] && !set_evt[2]) |=> !status_reg[2])
    else $error("write one did not clear buck three");

  // Read clears buck one status as well
  chk_read_clears_one: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && sel_status && !set_evt[0]) |=> !status_reg[0])
    else $error("read did not clear buck one");

  // Buck three unmasked status pulls the pin
  chk_pin_unmasked_three: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (status_reg[2] && !mask_reg[2]) |=> !o_irq_out_n)
    else $error("buck three left pin high");

  // Other groups' unmasked sources pull the pin
  chk_pin_ext_low: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_ext_irq |=> !o_irq_out_n)
    else $error("external source left pin high");

  // Other buck sources pull the pin
  chk_pin_other_low: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (|i_buck_other_irq) |=> !o_irq_out_n)
    else $error("other buck source left pin high");

  // Status reads back as stored, whatever the mask holds
  chk_status_read_back: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && sel_status) |=> o_rd_data == {UNUSED_ZERO, $past(status_reg)})
    else $error("status read back wrong");

  // Mask write lands in the low bits only
  chk_mask_write_lands: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_wr_en && sel_mask) |=> mask_reg == $past(i_wr_data[NUM_BUCK-1:0]))
    else $error("mask write lost");

  // Mask keeps its value with no write
  chk_mask_holds: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !(i_wr_en && sel_mask) |=> $stable(mask_reg))
    else $error("mask changed without write");

  // Mask reads back as stored
  chk_mask_read_back: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && sel_mask) |=> o_rd_data == {UNUSED_ZERO, $past(mask_reg)})
    else $error("mask read back wrong");

  // Live register shows the debounced level
  chk_live_read: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && sel_live) |=> o_rd_data == {UNUSED_ZERO, $past(live)})
    else $error("live read back wrong");

  // Unmapped reads return zero
  chk_unmapped_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_rd_en && !(sel_summary || sel_status || sel_mask || sel_live)) |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");

  // Read data stands until the next read
  chk_read_data_holds: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !i_rd_en |=> $stable(o_rd_data))
    else $error("read data changed without read");
endmodule : irq_summary

// ### irq_host_model.sv
// Host model: byte accesses on the block's register port.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
module irq_host_model
(
  input  wire logic       i_core_clk, // System clock
  input  wire logic [7:0] i_rd_data,  // Read data from block
  output logic      [7:0] o_addr,     // Register address
  output logic            o_wr_en,    // Write strobe
  output logic      [7:0] o_wr_data,  // Write data
  output logic            o_rd_en     // Read strobe
);
  // Idle bus before the first access
  initial
  begin
    o_addr    = 8'h00;
    o_wr_en   = 1'b0;
    o_wr_data = 8'h00;
    o_rd_en   = 1'b0;
  end
  // Released lines are scrambled so stale values cannot pass for data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_addr    <= a;
    o_wr_data <= d;
    o_wr_en   <= 1'b1;
    @(posedge i_core_clk);
    o_wr_en   <= 1'b0;
    o_addr    <= ~a;
    o_wr_data <= ~d;
  endtask : wr
  // Data lands on the edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_addr  <= a;
    o_rd_en <= 1'b1;
    @(posedge i_core_clk);
    o_rd_en <= 1'b0;
    o_addr  <= ~a;
    #1;
    d = i_rd_data;
  endtask : rd
endmodule : irq_host_model

// ### tb_top.sv
// Bench for the interrupt summary block with a short debounce.
// Assumes the host model in irq_host_model.sv.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module tb_top;
  import irq_summary_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr, wr_data, rd_data, grp = 8'h00;
  logic       wr_en, rd_en, irq_n, ext_irq = 1'b0;
  logic [2:0] fault = 3'h0, oth_irq = 3'h0;
  int         failures = 0, check_count = 0;
  always #5 clk = ~clk;
  irq_host_model host (.i_core_clk(clk), .i_rd_data(rd_data), .o_addr(addr),
    .o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en));
  // Short debounce keeps the run brief
  irq_summary #(.DEBOUNCE(4)) DUT (.i_core_clk(clk), .i_reset(rst),
    .i_addr(addr), .i_wr_en(wr_en), .i_wr_data(wr_data), .i_rd_en(rd_en),
    .o_rd_data(rd_data), .i_buck_fault(fault), .i_buck_other(grp[3:1]),
    .i_buck_other_irq(oth_irq), .i_charger_any(grp[0]), .i_linear_any(grp[4]),
    .i_button_any(grp[5]), .i_temp_any(grp[6]), .i_misc_any(grp[7]),
    .i_ext_irq(ext_irq), .o_irq_out_n(irq_n));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    `CHK(d, e)
  endtask : chk_rd
  // Bounded wait on the pin; running out ends the run
  task automatic wait_pin(input logic lvl);
    repeat (40)
      if (irq_n !== lvl)
        @(posedge clk);
    `CHK(irq_n, lvl)
    if (irq_n !== lvl)
      end_sim();
  endtask : wait_pin
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    chk_rd(LIMIT_MASK_ADR, 8'h07);
    chk_rd(LIMIT_STATUS_ADR, 8'h00);
    chk_rd(8'h20, 8'h00);
    host.wr(LIMIT_MASK_ADR, 8'hfe);
    chk_rd(LIMIT_MASK_ADR, 8'h06);
    // A two-cycle blip must be filtered out
    @(posedge clk);
    fault <= 3'h1;
    repeat (2) @(posedge clk);
    fault <= 3'h0;
    repeat (30) @(posedge clk);
    chk_rd(LIMIT_STATUS_ADR, 8'h00);
    host.wr(LIMIT_MASK_ADR, 8'h00);
    // Each buck: latch, hold after fault ends, clear by read or write
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      fault[i] <= 1'b1;
      wait_pin(1'b0);
      chk_rd(LIMIT_LIVE_ADR, 8'(1 << i));
      @(posedge clk);
      fault[i] <= 1'b0;
      repeat (30) @(posedge clk);
      chk_rd(GROUP_SUMMARY_ADR, 8'(2 << i));
      chk_rd(LIMIT_LIVE_ADR, 8'h00);
      if (i == 1)
        chk_rd(LIMIT_STATUS_ADR, 8'h02);
      else
        host.wr(LIMIT_STATUS_ADR, 8'(1 << i));
      chk_rd(GROUP_SUMMARY_ADR, 8'h00);
      wait_pin(1'b1);
    end
    // Masked source latches but leaves the pin alone
    host.wr(LIMIT_MASK_ADR, 8'h04);
    @(posedge clk);
    fault <= 3'h4;
    repeat (30) @(posedge clk);
    `CHK(irq_n, 1'b1)
    chk_rd(LIMIT_STATUS_ADR, 8'h04);
    // Other groups, with a write to the read-only summary
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk);
      grp <= 8'(1 << k);
      host.wr(GROUP_SUMMARY_ADR, 8'h00);
      chk_rd(GROUP_SUMMARY_ADR, 8'(1 << k));
    end
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      {oth_irq, ext_irq} <= 4'(1 << k);
      wait_pin(1'b0);
      @(posedge clk);
      {oth_irq, ext_irq} <= 4'h0;
      wait_pin(1'b1);
    end
    end_sim();
  end
endmodule : tb_top
